/* rtl/emod_cfg.svh */
// Offsets, field positions and reset values of the memory-operand datapath
`ifndef EMOD_CFG_SVH
`define EMOD_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EMOD_OFS_CTRL   8'h00
`define EMOD_OFS_ACC    8'h04
`define EMOD_OFS_MEM    8'h08
`define EMOD_OFS_FLAGS  8'h0C
`define EMOD_OFS_STATUS 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define EMOD_CTRL_OP_LSB  0
`define EMOD_CTRL_OP_MSB  4
`define EMOD_CTRL_BIT_LSB 5
`define EMOD_CTRL_BIT_MSB 7
`define EMOD_STAT_BUSY    0
`define EMOD_STAT_SKIP    1
`define EMOD_STAT_MEMWR   2

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define EMOD_ACC_RST    8'h00
`define EMOD_MEM_RST    8'h00
`define EMOD_FLAGS_RST  6'h00
`define EMOD_BYTE_ONES  8'hFF
`define EMOD_BYTE_ONE   8'h01
`define EMOD_BYTE_ZERO  8'h00

`endif

/* rtl/emod_pkg.sv */
// Types shared by the memory-operand datapath
package emod_pkg;

  typedef enum logic [4:0] {
    rotate_left_to_mem          = 5'h00,
    rotate_left_to_acc          = 5'h01,
    rotate_left_thru_carry_mem  = 5'h02,
    rotate_left_thru_carry_acc  = 5'h03,
    rotate_right_to_mem         = 5'h04,
    rotate_right_to_acc         = 5'h05,
    rotate_right_thru_carry_mem = 5'h06,
    rotate_right_thru_carry_acc = 5'h07,
    subtract_borrow_to_acc      = 5'h08,
    subtract_borrow_to_mem      = 5'h09,
    subtract_to_acc             = 5'h0A,
    subtract_to_mem             = 5'h0B,
    decrement_skip_zero_mem     = 5'h0C,
    decrement_skip_zero_acc     = 5'h0D,
    increment_skip_zero_mem     = 5'h0E,
    increment_skip_zero_acc     = 5'h0F,
    fill_ones                   = 5'h10,
    fill_one_bit                = 5'h11,
    skip_if_nonzero             = 5'h12,
    skip_if_bit_set             = 5'h13,
    skip_if_zero                = 5'h14,
    nibble_exchange_mem         = 5'h15,
    nibble_exchange_acc         = 5'h16
  } emod_op_type;

  typedef enum logic [1:0] {
    EMOD_IDLE  = 2'b00,
    EMOD_EXEC  = 2'b01,
    EMOD_SKIP1 = 2'b10,
    EMOD_SKIP2 = 2'b11
  } emod_state_type;

  // Bit 0 is carry
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_carry_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } emod_flags_type;

  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } emod_memwr_type;

endpackage

/* rtl/emod_datapath.sv */
// Memory-operand execution datapath with classic Wishbone register slave
//
// How it works
// RULE1: Rotate left to memory, bit 7 into bit 0, flags kept.
// RULE2: Rotate left result goes to accumulator, memory unchanged, flags kept.
// RULE3: Rotate left through carry to memory; only carry changes.
// RULE4: Rotate left through carry to accumulator; carry gets memory bit 7.
// RULE5: Rotate right to memory, bit 0 into bit 7, flags kept.
// RULE6: Rotate right result goes to accumulator, memory unchanged.
// RULE7: Rotate right through carry to memory; only carry changes.
// RULE8: Rotate right through carry to accumulator; carry gets memory bit 0.
// RULE9: Accumulator minus byte minus inverted carry into accumulator, six flags.
// RULE10: Subtraction carry is 0 on negative result, 1 otherwise.
// RULE11: Borrow subtraction to memory, same result and flags.
// RULE12: Plain subtraction into accumulator, same six flags.
// RULE13: Plain subtraction to memory, same flags as accumulator form.
// RULE14: Decrement memory byte, skip when zero, flags kept.
// RULE15: Decrement into accumulator, memory kept, skip when zero.
// RULE16: A skip adds a dummy cycle pair: three cycles in total.
// RULE17: Increment memory byte, skip when wrapped result is zero.
// RULE18: Increment into accumulator, memory kept, skip when zero.
// RULE19: Fill byte with ones, or set a single selected bit.
// RULE20: Skip when selected bit is one, flags kept.
// RULE21: Rewrite byte unchanged, skip when it is nonzero.
// RULE22: Swap nibbles, to memory or to accumulator.
// RULE23: Rewrite byte unchanged, skip when it is zero.
// RULE24: Unaffected flags hold; all arithmetic is eight bits, wrapping.
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps

`include "emod_cfg.svh"

module emod_datapath (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mem_we_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             skip_o,
  output logic             dummy_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  emod_pkg::emod_state_type state_q,   state_d;
  emod_pkg::emod_op_type    op_q,      op_d;
  emod_pkg::emod_flags_type flags_q,   flags_d;
  emod_pkg::emod_memwr_type memwr_q,   memwr_d;
  logic [2:0]               bit_q,     bit_d;
  logic [7:0]               acc_q,     acc_d;
  logic [7:0]               mem_q,     mem_d;
  logic                     skip_q,    skip_d;
  logic                     skipst_q,  skipst_d;
  logic                     dummy_q,   dummy_d;
  logic                     ack_q,     ack_d;
  logic [31:0]              rdat_q,    rdat_d;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic       bus_req;
  logic       bus_wr;
  logic       busy;
  logic [7:0] wbyte;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  // Only lane 0 carries register data; other lanes are ignored
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign busy    = (state_q != emod_pkg::EMOD_IDLE);
  assign wbyte   = wb_dat_i[7:0];

  // ****************************************************************
  // Datapath
  // ****************************************************************
  logic [8:0] diff9;
  logic [4:0] diff5;
  logic [7:0] sub_res;
  logic       bin;
  logic       with_borrow;
  logic       ov;
  logic       z_sub;
  logic [7:0] dec_res;
  logic [7:0] inc_res;
  logic [7:0] bit_mask;

  assign with_borrow = (op_q == emod_pkg::subtract_borrow_to_acc) |
                       (op_q == emod_pkg::subtract_borrow_to_mem);
  assign bin      = with_borrow & ~flags_q.carry_flag;  // RULE9
  assign diff9    = {1'b0, acc_q} - {1'b0, mem_q} - {8'h00, bin};
  assign diff5    = {1'b0, acc_q[3:0]} - {1'b0, mem_q[3:0]} - {4'h0, bin};
  assign sub_res  = diff9[7:0];
  assign ov       = (acc_q[7] ^ mem_q[7]) & (acc_q[7] ^ sub_res[7]);
  assign z_sub    = (sub_res == `EMOD_BYTE_ZERO);
  assign dec_res  = mem_q - `EMOD_BYTE_ONE;  // RULE24
  assign inc_res  = mem_q + `EMOD_BYTE_ONE;  // RULE24
  assign bit_mask = `EMOD_BYTE_ONE << bit_q;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d  = state_q;
    op_d     = op_q;
    bit_d    = bit_q;
    acc_d    = acc_q;
    mem_d    = mem_q;
    flags_d  = flags_q;  // RULE24
    memwr_d  = '0;
    skip_d   = 1'b0;
    skipst_d = skipst_q;
    dummy_d  = 1'b0;
    ack_d    = bus_req;
    rdat_d   = 32'h0000_0000;

    if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        `EMOD_OFS_CTRL:   rdat_d[7:0] = {bit_q, op_q};
        `EMOD_OFS_ACC:    rdat_d[7:0] = acc_q;
        `EMOD_OFS_MEM:    rdat_d[7:0] = mem_q;
        `EMOD_OFS_FLAGS:  rdat_d[5:0] = flags_q;
        `EMOD_OFS_STATUS: rdat_d[2:0] = {memwr_q.we, skipst_q, busy};
        default:          rdat_d      = 32'h0000_0000;
      endcase
    end

    // Writes are refused while an operation is in flight
    if (bus_wr && !busy) begin
      case (wb_adr_i)
        `EMOD_OFS_CTRL: begin
          op_d     = emod_pkg::emod_op_type'(
                       wbyte[`EMOD_CTRL_OP_MSB:`EMOD_CTRL_OP_LSB]);
          bit_d    = wbyte[`EMOD_CTRL_BIT_MSB:`EMOD_CTRL_BIT_LSB];
          skipst_d = 1'b0;
          state_d  = emod_pkg::EMOD_EXEC;
        end
        `EMOD_OFS_ACC:   acc_d   = wbyte;
        `EMOD_OFS_MEM:   mem_d   = wbyte;
        `EMOD_OFS_FLAGS: flags_d = wbyte[5:0];
        default: ;
      endcase
    end

    case (state_q)
      emod_pkg::EMOD_IDLE: ;
      emod_pkg::EMOD_EXEC: begin
        state_d = emod_pkg::EMOD_IDLE;
        case (op_q)
          emod_pkg::rotate_left_to_mem: begin
            memwr_d = {1'b1, mem_q[6:0], mem_q[7]};  // RULE1
          end
          emod_pkg::rotate_left_to_acc: begin
            acc_d = {mem_q[6:0], mem_q[7]};  // RULE2
          end
          emod_pkg::rotate_left_thru_carry_mem: begin
            memwr_d = {1'b1, mem_q[6:0], flags_q.carry_flag};  // RULE3
            flags_d.carry_flag = mem_q[7];  // RULE3
          end
          emod_pkg::rotate_left_thru_carry_acc: begin
            acc_d = {mem_q[6:0], flags_q.carry_flag};  // RULE4
            flags_d.carry_flag = mem_q[7];  // RULE4
          end
          emod_pkg::rotate_right_to_mem: begin
            memwr_d = {1'b1, mem_q[0], mem_q[7:1]};  // RULE5
          end
          emod_pkg::rotate_right_to_acc: begin
            acc_d = {mem_q[0], mem_q[7:1]};  // RULE6
          end
          emod_pkg::rotate_right_thru_carry_mem: begin
            memwr_d = {1'b1, flags_q.carry_flag, mem_q[7:1]};  // RULE7
            flags_d.carry_flag = mem_q[0];  // RULE7
          end
          emod_pkg::rotate_right_thru_carry_acc: begin
            acc_d = {flags_q.carry_flag, mem_q[7:1]};  // RULE8
            flags_d.carry_flag = mem_q[0];  // RULE8
          end
          emod_pkg::subtract_borrow_to_acc,
          emod_pkg::subtract_borrow_to_mem,
          emod_pkg::subtract_to_acc,
          emod_pkg::subtract_to_mem: begin
            if (op_q == emod_pkg::subtract_borrow_to_mem ||
                op_q == emod_pkg::subtract_to_mem) begin
              memwr_d = {1'b1, sub_res};  // RULE11 RULE13
            end else begin
              acc_d = sub_res;  // RULE9 RULE12
            end
            flags_d.carry_flag        = ~diff9[8];  // RULE10
            flags_d.half_carry_flag   = ~diff5[4];
            flags_d.signed_wrap_flag  = ov;
            flags_d.zero_flag         = z_sub;
            // Signed sign follows carry convention: 1 means non-negative
            flags_d.signed_carry_flag = ~(sub_res[7] ^ ov);
            // Chained zero carries previous zero across a borrow chain
            flags_d.chained_zero_flag = with_borrow ?
                                        (z_sub & flags_q.chained_zero_flag) :
                                        z_sub;  // RULE9 RULE12
          end
          emod_pkg::decrement_skip_zero_mem: begin
            memwr_d = {1'b1, dec_res};  // RULE14
            skip_d  = (dec_res == `EMOD_BYTE_ZERO);  // RULE14
          end
          emod_pkg::decrement_skip_zero_acc: begin
            acc_d  = dec_res;  // RULE15
            skip_d = (dec_res == `EMOD_BYTE_ZERO);  // RULE15
          end
          emod_pkg::increment_skip_zero_mem: begin
            memwr_d = {1'b1, inc_res};  // RULE17
            skip_d  = (inc_res == `EMOD_BYTE_ZERO);  // RULE17
          end
          emod_pkg::increment_skip_zero_acc: begin
            acc_d  = inc_res;  // RULE18
            skip_d = (inc_res == `EMOD_BYTE_ZERO);  // RULE18
          end
          emod_pkg::fill_ones: begin
            memwr_d = {1'b1, `EMOD_BYTE_ONES};  // RULE19
          end
          emod_pkg::fill_one_bit: begin
            memwr_d = {1'b1, mem_q | bit_mask};  // RULE19
          end
          emod_pkg::skip_if_bit_set: begin
            skip_d = |(mem_q & bit_mask);  // RULE20
          end
          emod_pkg::skip_if_nonzero: begin
            memwr_d = {1'b1, mem_q};  // RULE21
            skip_d  = (mem_q != `EMOD_BYTE_ZERO);  // RULE21
          end
          emod_pkg::skip_if_zero: begin
            memwr_d = {1'b1, mem_q};  // RULE23
            skip_d  = (mem_q == `EMOD_BYTE_ZERO);  // RULE23
          end
          emod_pkg::nibble_exchange_mem: begin
            memwr_d = {1'b1, mem_q[3:0], mem_q[7:4]};  // RULE22
          end
          emod_pkg::nibble_exchange_acc: begin
            acc_d = {mem_q[3:0], mem_q[7:4]};  // RULE22
          end
          default: ;
        endcase
        if (memwr_d.we) begin
          mem_d = memwr_d.data;
        end
        if (skip_d) begin
          skipst_d = 1'b1;
          state_d  = emod_pkg::EMOD_SKIP1;  // RULE16
          dummy_d  = 1'b1;  // RULE16
        end
      end
      emod_pkg::EMOD_SKIP1: begin
        state_d = emod_pkg::EMOD_SKIP2;  // RULE16
        dummy_d = 1'b1;  // RULE16
      end
      emod_pkg::EMOD_SKIP2: begin
        state_d = emod_pkg::EMOD_IDLE;
      end
      default: begin
        state_d = emod_pkg::EMOD_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= emod_pkg::EMOD_IDLE;
      op_q     <= emod_pkg::rotate_left_to_mem;
      bit_q    <= 3'h0;
      acc_q    <= `EMOD_ACC_RST;
      mem_q    <= `EMOD_MEM_RST;
      flags_q  <= `EMOD_FLAGS_RST;
      memwr_q  <= '0;
      skip_q   <= 1'b0;
      skipst_q <= 1'b0;
      dummy_q  <= 1'b0;
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
    end else begin
      state_q  <= state_d;
      op_q     <= op_d;
      bit_q    <= bit_d;
      acc_q    <= acc_d;
      mem_q    <= mem_d;
      flags_q  <= flags_d;
      memwr_q  <= memwr_d;
      skip_q   <= skip_d;
      skipst_q <= skipst_d;
      dummy_q  <= dummy_d;
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
    end
  end

  assign wb_dat_o    = rdat_q;
  assign wb_ack_o    = ack_q;
  assign mem_we_o    = memwr_q.we;
  assign mem_wdata_o = memwr_q.data;
  assign skip_o      = skip_q;
  assign dummy_o     = dummy_q;

endmodule

/* tb/emod_datapath_checker.sv */
// Port assertions for the memory-operand datapath
`timescale 1ns/100ps
module emod_datapath_checker (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        mem_we_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        skip_o,
  input wire logic        dummy_o
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic       go;
  logic [4:0] op;
  // Dummy slot doubles as busy flag: writes then are dropped
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !dummy_o
              && wb_adr_i == 8'h00 && wb_sel_i[0];
  assign op = wb_dat_i[4:0];
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_FILL_ONES: assert property (go && op == 5'h10 |-> ##2 mem_we_o && mem_wdata_o == 8'hFF)
    else $error("fill did not write all ones");
  AST_SET_BIT: assert property (go && op == 5'h11 |-> ##2 mem_we_o && !skip_o)
    else $error("set bit did not write back");
  AST_ACC_DEST: assert property (go && op inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h08, 5'h0A, 5'h0D, 5'h0F, 5'h16} |-> ##2 !mem_we_o)
    else $error("accumulator form wrote memory");
  AST_BIT_TEST: assert property (go && op == 5'h13 |-> ##2 !mem_we_o)
    else $error("bit test wrote memory");
  AST_REWRITE: assert property (go && op inside {5'h12, 5'h14} |-> ##2 mem_we_o)
    else $error("byte test did not rewrite");
  AST_SKIP_SLOT: assert property (skip_o |-> dummy_o ##1 dummy_o ##1 !dummy_o)
    else $error("dummy slot not two cycles");
  AST_DUMMY_CAUSE: assert property ($rose(dummy_o) |-> skip_o)
    else $error("dummy slot without skip");
  AST_SKIP_PULSE: assert property (skip_o |=> !skip_o)
    else $error("skip longer than one cycle");
  cover property (skip_o);
  cover property (go && op == 5'h10);
  cover property (go && op == 5'h13);
endmodule
bind emod_datapath emod_datapath_checker u_chk (
  .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
  .skip_o(skip_o), .dummy_o(dummy_o)
);

/* tb/emod_seq_model.sv */
// Data memory and sequencer model on the datapath's far side
`timescale 1ns/100ps
module emod_seq_model (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       mem_we_o,
  input  wire logic [7:0] mem_wdata_o,
  input  wire logic       skip_o,
  input  wire logic       dummy_o,
  output logic      [7:0] mem_byte,
  output int              n_skip,
  output int              n_dummy
);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_byte <= 8'h00;
      n_skip <= 0;
      n_dummy <= 0;
    end else begin
      if (mem_we_o) begin
        mem_byte <= mem_wdata_o;
      end
      // Fetch slot is burnt while the dummy is present
      if (skip_o) begin
        n_skip <= n_skip + 1;
      end
      if (dummy_o) begin
        n_dummy <= n_dummy + 1;
      end
    end
  end
endmodule

/* tb/emod_datapath_test.sv */
// Self-checking bench for the memory-operand datapath
`timescale 1ns/100ps
`include "emod_cfg.svh"
module emod_datapath_test;
  logic        core_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, mem_we_o, skip_o, dummy_o;
  logic [7:0]  mem_wdata_o, mem_byte, rd;
  int          n_fail = 0, n_checks = 0, n_skip_exp = 0;
  int          n_skip, n_dummy, i;
  always #5 core_clk = ~core_clk;
  emod_datapath dut (.core_clk(core_clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_we_o(mem_we_o),
    .mem_wdata_o(mem_wdata_o), .skip_o(skip_o), .dummy_o(dummy_o));
  emod_seq_model u_seq (.core_clk(core_clk), .resetn(resetn),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .skip_o(skip_o),
    .dummy_o(dummy_o), .mem_byte(mem_byte), .n_skip(n_skip),
    .n_dummy(n_dummy));
  // Result: {memwrite, skip, flags, acc, mem}
  function automatic logic [23:0] expect_op(input logic [4:0] op,
      input logic [2:0] b, input logic [7:0] a, input logic [7:0] m,
      input logic [5:0] f);
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] r;
    logic [5:0] nf;
    logic       sk, bw, ta, ov;
    r = m;
    nf = f;
    sk = 1'h0;
    bw = !op[1] && !f[0];
    ta = (op < 5'h10) ? (op[0] ^ (op[3] & !op[2])) : (op == 5'h16);
    case (op)
      5'h00, 5'h01: r = {m[6:0], m[7]};
      5'h02, 5'h03: begin r = {m[6:0], f[0]}; nf[0] = m[7]; end
      5'h04, 5'h05: r = {m[0], m[7:1]};
      5'h06, 5'h07: begin r = {f[0], m[7:1]}; nf[0] = m[0]; end
      5'h08, 5'h09, 5'h0A, 5'h0B: begin
        d = {1'h0, a} - {1'h0, m} - {8'h00, bw};
        h = {1'h0, a[3:0]} - {1'h0, m[3:0]} - {4'h0, bw};
        r = d[7:0];
        ov = (a[7] != m[7]) && (r[7] != a[7]);
        nf = {(r == 8'h00) && (op[1] || f[5]), !(r[7] ^ ov), ov,
              r == 8'h00, !h[4], !d[8]};
      end
      5'h0C, 5'h0D: begin r = m - 8'h01; sk = (r == 8'h00); end
      5'h0E, 5'h0F: begin r = m + 8'h01; sk = (r == 8'h00); end
      5'h10: r = 8'hFF;
      5'h11: r = m | (8'h01 << b);
      5'h12: sk = (m != 8'h00);
      5'h13: sk = m[b];
      5'h14: sk = (m == 8'h00);
      default: r = {m[3:0], m[7:4]};
    endcase
    return {!ta && op != 5'h13, sk, nf, ta ? r : a, ta ? m : r};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Classic cycle: hold everything until ack is seen, then idle a cycle
  task automatic wb(input logic we, input logic [7:0] adr,
      input logic [7:0] dat, output logic [7:0] rdata);
    int n;
    n = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, dat};
    do begin @(posedge core_clk); n++; end
    while (wb_ack_o !== 1'h1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      report_and_stop();
    end
    rdata = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic run_op(input logic [4:0] op, input logic [2:0] b,
      input logic [7:0] a, input logic [7:0] m, input logic [5:0] f);
    logic [7:0]  r;
    logic [23:0] e;
    int          n;
    e = expect_op(op, b, a, m, f);
    n_skip_exp += int'(e[22]);
    wb(1'h1, `EMOD_OFS_ACC, a, r);
    wb(1'h1, `EMOD_OFS_MEM, m, r);
    wb(1'h1, `EMOD_OFS_FLAGS, {2'h0, f}, r);
    wb(1'h1, `EMOD_OFS_CTRL, {b, op}, r);
    n = 0;
    do begin wb(1'h0, `EMOD_OFS_STATUS, 8'h00, r); n++; end
    while (r[0] !== 1'h0 && n < 8);
    chk({7'h00, r[0]}, 8'h00);
    chk({7'h00, r[1]}, {7'h00, e[22]});
    wb(1'h0, `EMOD_OFS_ACC, 8'h00, r);
    chk(r, e[15:8]);
    wb(1'h0, `EMOD_OFS_MEM, 8'h00, r);
    chk(r, e[7:0]);
    wb(1'h0, `EMOD_OFS_FLAGS, 8'h00, r);
    chk(r, {2'h0, e[21:16]});
    if (e[23]) begin
      chk(mem_byte, e[7:0]);
    end
  endtask
  initial begin
    i = int'($urandom(90));
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    wb(1'h0, 8'h14, 8'h00, rd);
    chk(rd, 8'h00);
    // Every op code once with boundary bytes
    for (i = 0; i < 23; i++) begin
      run_op(5'(i), 3'(i), 8'h80, i[0] ? 8'hFF : 8'h01, i[1] ? 6'h3F : 6'h20);
    end
    run_op(5'h0E, 3'h0, 8'h00, 8'hFF, 6'h15);
    run_op(5'h0F, 3'h0, 8'h00, 8'hFF, 6'h2A);
    run_op(5'h0C, 3'h0, 8'h00, 8'h01, 6'h00);
    run_op(5'h08, 3'h0, 8'h00, 8'h00, 6'h00);
    run_op(5'h0B, 3'h0, 8'h80, 8'h01, 6'h3F);
    run_op(5'h13, 3'h7, 8'h00, 8'h7F, 6'h00);
    for (i = 0; i < 120; i++) begin
      run_op(5'($urandom_range(22, 0)), 3'($urandom), 8'($urandom), 8'($urandom), 6'($urandom));
    end
    chk(8'(n_skip), 8'(n_skip_exp));
    chk(8'(n_dummy), 8'(2 * n_skip_exp));
    report_and_stop();
  end
endmodule
